// File: verilog/cecr_core.sv
// Purpose: Receive side of a single-wire control bus, with register port
// Assumes: cec_in is synchronous to mclk; cec_oe high pulls the line low
// Notes:   Reading status clears it; reading the buffer frees it
`timescale 1ns/1ps
`default_nettype none

module cecr_core
    import cecr_pkg::*;
#(
    parameter int FS_DIV_P = FS_DIV
) (
    // Clock and reset
    input  wire logic            mclk,
    input  wire logic            rst,
    // Register port
    input  wire cecr_req_s       req,
    output var  logic [31:0]     rdata,
    // Bus line
    input  wire logic            cec_in,
    output var  logic            cec_oe,
    // Flags toward interrupt logic
    output var  logic [NFLG-1:0] rx_status_flags
);

    localparam logic [DIVW-1:0] DIV_LAST = DIVW'(FS_DIV_P - 1);

    typedef struct packed {
        logic [DIVW-1:0]   div;
        logic              tick;
        logic [2:0]        nf_cnt;
        logic              filt;
        cecr_state_e       st;
        logic [TW-1:0]     t;
        logic              rose;
        logic [3:0]        idx;
        logic [BLK_W-1:0]  shift;
        logic              hdr;
        logic              match;
        logic [NFLG-1:0]   pend;
        logic [TW-1:0]     drv_cnt;
        logic              line_oe;
        logic [BLK_W-1:0]  rx_block_buffer;
        logic              buf_full;
        logic [NFLG-1:0]   status;
        logic [AMAP_W-1:0] addr_map;
        cecr_ctrl1_s       rx_control_one;
        cecr_ctrl2_s       rx_control_two;
        cecr_ctrl3_s       rx_control_three;
        logic              enable;
        logic [31:0]       rdata;
    } cecr_reg_s;

    cecr_reg_s s;
    cecr_reg_s n;
    logic      fall;
    logic      rise;

    always_comb begin
        logic [TW-1:0]     tn;
        logic [TW-1:0]     min_lim;
        logic [TW-1:0]     max_lim;
        logic [TW-1:0]     dec_pt;
        logic [TW-1:0]     tout;
        logic [NFLG-1:0]   setf;
        logic [NFLG-1:0]   errf;
        logic [LA_W-1:0]   dest;
        logic              complete;
        logic              want;
        logic              hard;
        cecr_ctrl1_s       c1;
        cecr_ctrl2_s       c2;
        cecr_ctrl3_s       c3;
        tn       = '0;
        min_lim  = '0;
        max_lim  = '0;
        dec_pt   = '0;
        tout     = '0;
        setf     = '0;
        errf     = '0;
        dest     = '0;
        complete = 1'b0;
        want     = 1'b0;
        hard     = 1'b0;
        fall     = 1'b0;
        rise     = 1'b0;
        c1       = s.rx_control_one;
        c2       = s.rx_control_two;
        c3       = s.rx_control_three;
        n        = s;
        n.rdata  = '0;
        // Sample tick divider
        n.tick = (s.div == DIV_LAST);
        n.div  = n.tick ? '0 : s.div + 1'b1;

        if (req.wr) begin
            case (req.addr)
                REG_ADDR_MAP: n.addr_map = req.wdata[AMAP_W-1:0];
                REG_CTRL1:    n.rx_control_one = req.wdata;
                REG_CTRL2:    n.rx_control_two = req.wdata;
                REG_CTRL3:    n.rx_control_three = req.wdata;
                REG_ENABLE:   n.enable = req.wdata[0];
                default:      ; // Status and buffer ignore writes
            endcase
        end
        if (req.rd) begin
            case (req.addr)
                REG_ADDR_MAP: n.rdata = 32'(s.addr_map);
                REG_CTRL1:    n.rdata = s.rx_control_one;
                REG_CTRL2:    n.rdata = s.rx_control_two;
                REG_CTRL3:    n.rdata = s.rx_control_three;
                REG_STATUS: begin
                    n.rdata  = 32'(s.status);
                    n.status = '0;
                end
                REG_BUF: begin
                    n.rdata    = 32'(s.rx_block_buffer);
                    n.buf_full = 1'b0;
                end
                REG_ENABLE:   n.rdata = 32'(s.enable);
                default:      n.rdata = '0;
            endcase
        end

        // Noise filter: flip after code plus one equal samples
        if (s.tick) begin
            if (cec_in == s.filt) begin
                n.nf_cnt = '0;
            end else if (s.nf_cnt == (s.filt ? c1.lnc
                                             : {1'b0, c1.hnc})) begin
                n.filt   = cec_in;
                n.nf_cnt = '0;
                fall     = s.filt;
                rise     = !s.filt;
            end else begin
                n.nf_cnt = s.nf_cnt + 1'b1;
            end
            if (s.drv_cnt != '0) begin
                n.drv_cnt = s.drv_cnt - 1'b1;
            end
        end

        tn      = (s.t == '1) ? s.t : s.t + 1'b1;
        min_lim = CYC_MIN_FS + TW'($signed(c1.min_adj));
        max_lim = CYC_MAX_FS + TW'($signed(c1.max_adj));
        dec_pt  = DECIDE_FS + TW'($signed({c1.bit_decide_point, 1'b0}));
        tout    = TW'((32'(c1.suspend_timeout_len) + 1) * 32'(CYC_MAX_FS));

        if (s.tick && s.enable) begin
            case (s.st)
                ST_IDLE: begin
                    if (fall) begin
                        n.st   = ST_START;
                        n.t    = '0;
                        n.rose = 1'b0;
                    end
                end
                ST_START: begin
                    n.t = tn;
                    if (rise) begin
                        if (tn < TW'(c2.start_rise_earliest) ||
                            tn > TW'(c2.start_rise_latest)) begin
                            n.st = ST_IDLE;
                        end else begin
                            n.rose = 1'b1;
                        end
                    end
                    if (fall) begin
                        n.t    = '0;
                        n.rose = 1'b0;
                        if (s.rose && tn >= TW'(c2.start_cycle_min) &&
                            tn <= TW'(c2.start_cycle_max)) begin
                            setf[FLG_START] = 1'b1;
                            n.st    = ST_BIT;
                            n.idx   = '0;
                            n.hdr   = 1'b1;
                            n.match = 1'b0;
                            n.shift = '0;
                        end
                    end else if (tn > TW'(c2.start_cycle_max) ||
                                 (!s.rose && tn > TW'(c2.start_rise_latest)))
                    begin
                        n.st = ST_IDLE;
                    end
                end
                ST_BIT: begin
                    n.t = tn;
                    if (rise) begin
                        n.rose = 1'b1;
                        if (c1.shape_check_enable &&
                            (tn < TW'(c3.shape_window_zero) ||
                             (tn > TW'(c3.shape_window_one) &&
                              tn < TW'(c3.shape_window_two)))) begin
                            errf[FLG_SHAPE] = 1'b1;
                        end
                    end else if (!s.rose && c1.shape_check_enable &&
                                 tn == TW'(c3.shape_window_three)) begin
                        errf[FLG_SHAPE] = 1'b1;
                    end
                    if (tn == dec_pt) begin
                        // Ack bit is shifted in as seen
                        n.shift = {s.shift[BLK_W-2:0], s.filt};
                        if (s.idx == IDX_ACK) begin
                            complete = 1'b1;
                            if (s.buf_full) begin
                                errf[FLG_OVR] = 1'b1;
                            end else begin
                                n.rx_block_buffer = n.shift;
                                n.buf_full        = 1'b1;
                            end
                            n.idx = '0;
                            n.hdr = 1'b0;
                        end else begin
                            n.idx = s.idx + 1'b1;
                            if (s.hdr && s.idx == IDX_LAST_DATA) begin
                                dest    = n.shift[LA_W-1:0];
                                n.match = s.addr_map[dest];
                                if (!n.match && dest != BROADCAST &&
                                    !c1.other_addr) begin
                                    n.st = ST_IDLE;
                                end
                            end
                        end
                    end
                    if (fall) begin
                        if (tn < min_lim) begin
                            errf[FLG_SHORT] = 1'b1;
                        end else begin
                            n.t    = '0;
                            n.rose = 1'b0;
                            if (s.idx == IDX_ACK) begin
                                // No match, incl. other-address: no ack; pending errors invert this
                                want = s.match && (s.hdr || !c1.ack_disable);
                                if (s.pend != '0) begin
                                    want = !want;
                                end
                                if (want) begin
                                    n.drv_cnt = ACK_LOW_FS;
                                end
                            end
                        end
                    end else if (tn == max_lim) begin
                        errf[FLG_LONG] = 1'b1;
                    end
                end
                default: n.st = ST_IDLE;
            endcase

            if (errf != '0) begin
                hard = errf[FLG_SHORT] || !c1.error_suspend_enable ||
                       (errf[FLG_LONG] && !s.filt);
                if (hard) begin
                    setf   = setf | errf | s.pend;
                    n.pend = '0;
                    n.st   = ST_IDLE;
                    if (errf[FLG_SHORT]) begin
                        n.drv_cnt = ERR_LOW_FS;
                    end
                    if (errf[FLG_LONG] && !s.filt) begin
                        // Low line past the limit is a new start
                        n.st   = ST_START;
                        n.t    = tn;
                        n.rose = 1'b0;
                    end
                end else begin
                    n.pend = s.pend | errf;
                end
            end
            if (complete && !hard) begin
                setf[FLG_DONE] = 1'b1;
                setf = setf | n.pend;
                if (n.shift[1]) begin
                    n.st   = ST_IDLE;
                    n.pend = '0;
                end
            end
            if (s.st == ST_BIT && n.st == ST_BIT && n.pend != '0 &&
                !fall && tn >= tout) begin
                setf   = setf | n.pend;
                n.pend = '0;
                n.st   = ST_IDLE;
            end
        end
        if (!s.enable) begin
            n.st      = ST_IDLE;
            n.pend    = '0;
            n.drv_cnt = '0;
        end
        n.status  = n.status | setf; // Set wins over read clear
        n.line_oe = (n.drv_cnt != '0);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s                  <= '0;
            s.filt             <= 1'b1;
            s.rx_control_one   <= CTRL1_RST;
            s.rx_control_two   <= CTRL2_RST;
            s.rx_control_three <= CTRL3_RST;
        end else begin
            s <= n;
        end
    end

    assign rdata           = s.rdata;
    assign cec_oe          = s.line_oe;
    assign rx_status_flags = s.status;

    // Cycles between the cycle after a tick and the next tick
    localparam int TICK_WAIT = FS_DIV_P - 1;

    chk_tick_period: assert property (@(posedge mclk) disable iff (rst)
        s.tick |-> ##1 !s.tick ##[TICK_WAIT:TICK_WAIT] s.tick)
        else $error("sample tick spacing wrong");

    chk_start_flag: assert property (@(posedge mclk) disable iff (rst)
        (s.st == ST_START && n.st == ST_BIT) |=> s.status[FLG_START])
        else $error("start flag not set on valid start");

    chk_done_store: assert property (@(posedge mclk) disable iff (rst)
        $rose(s.status[FLG_DONE]) && !$past(s.status[FLG_OVR]) &&
        !s.status[FLG_OVR] |-> s.buf_full)
        else $error("done flag without stored block");

    chk_filter_low: assert property (@(posedge mclk) disable iff (rst)
        $fell(s.filt) |-> $past(s.nf_cnt) == $past(s.rx_control_one.lnc))
        else $error("low filter count mismatch");

    chk_drive_len: assert property (@(posedge mclk) disable iff (rst)
        $rose(s.line_oe) |-> (s.drv_cnt == ACK_LOW_FS ||
                              s.drv_cnt == ERR_LOW_FS))
        else $error("line drive length wrong");

    chk_short_drive: assert property (@(posedge mclk) disable iff (rst)
        $rose(s.status[FLG_SHORT]) && !$past(req.rd) |->
        s.drv_cnt == ERR_LOW_FS)
        else $error("short cycle error without low drive");

    chk_status_ro: assert property (@(posedge mclk) disable iff (rst)
        (req.wr && !req.rd) |=> ($past(s.status) & ~s.status) == '0)
        else $error("write altered status");

    chk_stop_drive: assert property (@(posedge mclk) disable iff (rst)
        !s.enable |=> !s.line_oe && s.st == ST_IDLE)
        else $error("disabled receiver still active");

    chk_suspend_hold: assert property (@(posedge mclk) disable iff (rst)
        (s.st == ST_BIT && n.st == ST_BIT && n.pend[FLG_SHAPE] &&
         !s.pend[FLG_SHAPE]) |=> !$rose(s.status[FLG_SHAPE]))
        else $error("suspended error flagged at once");

    cov_start: cover property (@(posedge mclk) disable iff (rst)
        $rose(s.status[FLG_START]));
    cov_done: cover property (@(posedge mclk) disable iff (rst)
        $rose(s.status[FLG_DONE]));
    cov_ack: cover property (@(posedge mclk) disable iff (rst)
        $rose(s.line_oe) && s.drv_cnt == ACK_LOW_FS);
    cov_short: cover property (@(posedge mclk) disable iff (rst)
        $rose(s.status[FLG_SHORT]));

endmodule

`default_nettype wire

// File: shared/cecr_pkg.sv
// Purpose: Constants, register layouts and state types of the receiver core
// Assumes: 10 MHz mclk, sample tick derived at 32.768 kHz
// Notes:   Times are kept in sample-tick units, the filter works on raw taps
package cecr_pkg;

    localparam int MCLK_HZ = 10_000_000;
    localparam int FS_HZ   = 32768;
    localparam int FS_DIV  = MCLK_HZ / FS_HZ;
    localparam int DIVW    = 9;
    localparam int TW      = 10;
    localparam int NFLG    = 7;
    localparam int BLK_W   = 10;
    localparam int LA_W    = 4;
    localparam int AMAP_W  = 16;

    localparam int ACK_LOW_US = 1526;
    localparam int ERR_LOW_US = 3630;

    localparam logic [TW-1:0] CYC_MIN_FS  = 10'h043;
    localparam logic [TW-1:0] CYC_MAX_FS  = 10'h05A;
    localparam logic [TW-1:0] DECIDE_FS   = 10'h022;
    localparam logic [TW-1:0] ACK_LOW_FS  =
        TW'(ACK_LOW_US * FS_HZ / 1_000_000);
    localparam logic [TW-1:0] ERR_LOW_FS  =
        TW'(ERR_LOW_US * FS_HZ / 1_000_000);

    localparam logic [3:0] REG_ADDR_MAP = 4'h0;
    localparam logic [3:0] REG_CTRL1    = 4'h1;
    localparam logic [3:0] REG_CTRL2    = 4'h2;
    localparam logic [3:0] REG_CTRL3    = 4'h3;
    localparam logic [3:0] REG_STATUS   = 4'h4;
    localparam logic [3:0] REG_BUF      = 4'h5;
    localparam logic [3:0] REG_ENABLE   = 4'h6;

    localparam int FLG_DONE   = 0;
    localparam int FLG_START  = 1;
    localparam int FLG_LONG   = 2;
    localparam int FLG_SHORT  = 3;
    localparam int FLG_ACKCOL = 4;
    localparam int FLG_OVR    = 5;
    localparam int FLG_SHAPE  = 6;

    localparam logic [3:0]  IDX_LAST_DATA = 4'h7;
    localparam logic [3:0]  IDX_ACK       = 4'h9;
    localparam logic [LA_W-1:0] BROADCAST = 4'hF;
    localparam logic [31:0] CTRL1_RST     = 32'h0000_0000;
    localparam logic [31:0] CTRL2_RST     = 32'h9A8D_8073;
    localparam logic [31:0] CTRL3_RST     = 32'h382B_1A0D;

    typedef struct packed {
        logic [10:0] rsvd;
        logic        shape_check_enable;
        logic [2:0]  suspend_timeout_len;
        logic        error_suspend_enable;
        logic        other_addr;
        logic        ack_disable;
        logic [2:0]  bit_decide_point;
        logic [2:0]  max_adj;
        logic [2:0]  min_adj;
        logic [2:0]  lnc;
        logic [1:0]  hnc;
    } cecr_ctrl1_s;

    typedef struct packed {
        logic [7:0] start_cycle_max;
        logic [7:0] start_cycle_min;
        logic [7:0] start_rise_latest;
        logic [7:0] start_rise_earliest;
    } cecr_ctrl2_s;

    typedef struct packed {
        logic [7:0] shape_window_three;
        logic [7:0] shape_window_two;
        logic [7:0] shape_window_one;
        logic [7:0] shape_window_zero;
    } cecr_ctrl3_s;

    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } cecr_req_s;

    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BIT} cecr_state_e;

endpackage

// File: test/cecr_init_model.sv
// Purpose: Initiator on the shared control line, for the receiver bench
// Assumes: One sample tick is T mclk cycles
// Notes:   Drives the line low only; a released line is pulled high
`timescale 1ns/1ps
`default_nettype none
module cecr_init_model #(
    parameter int T = 8
) (
    // Clock
    input  wire logic mclk,
    // Line
    input  wire logic line,
    output var  logic drv_low
);
    initial drv_low = 1'b0;

    // Wait n sample ticks
    task automatic wt(input int n);
        repeat (n * T) @(posedge mclk);
    endtask

    // One bit: low for lo ticks, g opens a two-tick gap in the low;
    // the line is read 35 ticks in, where the ack slot is decided
    task automatic bit_out(input int lo, per, g, output logic seen);
        for (int i = 0; i < per; i++) begin
            drv_low <= i < lo && !(i >= g && i < g + 2);
            if (i == 35)
                seen = line;
            wt(1);
        end
    endtask

    // Eight data bits MSB first, end of message, ack slot sent as a 1
    task automatic block(input logic [7:0] d, input logic eom,
                         output logic ack);
        logic [9:0] b;
        b = {d, eom, 1'b1};
        for (int k = 9; k >= 0; k--)
            bit_out(b[k] ? 20 : 49, 79, -10, ack);
    endtask
endmodule
`default_nettype wire

// File: test/tb.sv
// Purpose: Self-checking bench for the receiver core
// Assumes: Sample tick shortened to T mclk cycles
// Notes:   Expected acks come from the bench's config copy; expected flags are fixed values
`timescale 1ns/1ps
`default_nettype none
module tb import cecr_pkg::*; ;
    localparam int T = 8;
    logic            mclk;
    logic            rst;
    logic            line;
    logic            drv_low;
    logic            cec_oe;
    cecr_req_s       req;
    logic [31:0]     rdata;
    logic [31:0]     rv;
    logic [31:0]     seed;
    logic [15:0]     map;
    logic            adis;
    logic [NFLG-1:0] flags;
    int              n_mismatch;
    int              check_count;
    int              oe_len;
    int              oe_last;

    assign line = !(drv_low || cec_oe === 1'b1);

    cecr_core #(.FS_DIV_P(T)) i_dut (
        .mclk            (mclk),
        .rst             (rst),
        .req             (req),
        .rdata           (rdata),
        .cec_in          (line),
        .cec_oe          (cec_oe),
        .rx_status_flags (flags)
    );
    cecr_init_model #(.T(T)) i_init (
        .mclk    (mclk),
        .line    (line),
        .drv_low (drv_low)
    );

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // Length of the last pull-low by the design, in mclk cycles
    always @(posedge mclk) begin
        if (cec_oe)
            oe_len <= oe_len + 1;
        else if (oe_len != 0) begin
            oe_last <= oe_len;
            oe_len  <= 0;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // Ack slot level the initiator should see
    function automatic logic exp_ack(input logic hd, input logic [3:0] dst);
        return !(map[dst] && (hd || !adis));
    endfunction

    // One register access; read data taken in the cycle after the strobe
    task automatic bus(input logic [3:0] a, input logic [31:0] d,
                       input logic w, output logic [31:0] q);
        req <= '{a, d, w, !w};
        @(posedge mclk);
        req <= '0;
        @(posedge mclk);
        q = rdata;
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
        bus(a, 32'h0, 1'b0, rv);
        chk(rv, e);
    endtask

    task automatic set(input logic [15:0] m, input logic [31:0] c1);
        map  = m;
        adis = c1[14];
        bus(REG_ADDR_MAP, {16'h0, m}, 1'b1, rv);
        // Low filter code comes from c1 bits 4:2, written as given
        bus(REG_CTRL1, c1, 1'b1, rv);
        bus(REG_ENABLE, 32'h1, 1'b1, rv);
        rdchk(REG_ADDR_MAP, {16'h0, m});
        rdchk(REG_ENABLE, 32'h1);
    endtask

    // Start bit, then the header block and nb-1 blocks of random data; the last ends the message
    task automatic frame(input logic [7:0] hdr, input int nb,
                         input logic rb, input int g);
        logic [7:0] d;
        logic       e;
        logic       a;
        i_init.bit_out(121, 148, g, a);
        for (int k = 0; k < nb; k++) begin
            d = (k == 0) ? hdr : seed[7:0];
            e = (k == nb - 1);
            seed = xs(seed);
            i_init.block(d, e, a);
            chk(32'(a), 32'(exp_ack(k == 0, hdr[3:0])));
            if (rb) begin
                chk(32'(flags), (k == 0) ? 32'h3 : 32'h1);
                rdchk(REG_STATUS, (k == 0) ? 32'h3 : 32'h1);
                rdchk(REG_BUF, {22'h0, d, e, a});
            end
        end
    endtask

    // Start, a shaped bit, one normal bit, then a quiet line
    task automatic bad(input int slo, blo, bper, input logic [31:0] st);
        logic s;
        i_init.bit_out(slo, 148, -10, s);
        i_init.bit_out(blo, bper, -10, s);
        i_init.bit_out(20, 79, -10, s);
        i_init.wt(140);
        rdchk(REG_STATUS, st);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        rst         = 1'b1;
        req         = '0;
        seed        = 32'h4C1B;
        map         = 16'h0;
        adis        = 1'b0;
        n_mismatch  = 0;
        check_count = 0;
        oe_len      = 0;
        oe_last     = 0;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        bus(REG_STATUS, 32'h7F, 1'b1, rv);
        bus(4'hC, 32'hFFFF_FFFF, 1'b1, rv);
        rdchk(REG_STATUS, 32'h0);
        rdchk(4'hC, 32'h0);
        rdchk(REG_CTRL1, CTRL1_RST);
        rdchk(REG_CTRL2, CTRL2_RST);
        rdchk(REG_CTRL3, CTRL3_RST);
        set(16'h0030, 32'h0);
        frame(8'h04, 2, 1'b1, -10);
        chk(32'((oe_last + T / 2) / T), 32'(ACK_LOW_FS));
        set(16'h0030, 32'h4000);
        frame(8'h15, 2, 1'b1, -10);
        frame(8'h0F, 1, 1'b1, -10);
        set(16'h8000, 32'h0);
        frame(8'h0F, 1, 1'b1, -10);
        set(16'h0001, 32'h8000);
        frame(8'h03, 1, 1'b1, -10);
        set(16'h0010, 32'h000E);
        frame(8'h04, 1, 1'b1, 60);
        set(16'h0010, 32'h0);
        frame(8'h04, 2, 1'b0, -10);
        rdchk(REG_STATUS, 32'h23);
        bad(100, 20, 79, 32'h0);
        bad(121, 20, 50, 32'h0A);
        chk(32'((oe_last + T / 2) / T), 32'(ERR_LOW_FS));
        bad(121, 20, 79, 32'h06);
        set(16'h0010, 32'h0010_0000);
        bad(121, 30, 79, 32'h42);
        // Suspended shape error, then timeout raises shape and long
        set(16'h0010, 32'h0011_0000);
        bad(121, 30, 79, 32'h46);
        end_sim;
    end

    initial begin
        repeat (98000) @(posedge mclk);
        n_mismatch++;
        end_sim;
    end
endmodule
`default_nettype wire
